// ===== rtl/aacc_params.svh
// Offsets, field positions, reset values and counts of the arithmetic accelerator
`ifndef AACC_PARAMS_SVH
`define AACC_PARAMS_SVH

// ---------------------------------------------------------------
// Accelerator register addresses on the register port
// ---------------------------------------------------------------
`define AACC_ADDR_MODE     8'hD1
`define AACC_ADDR_CTRL     8'hD2
`define AACC_ADDR_OPA      8'hD3
`define AACC_ADDR_OPB      8'hD4
`define AACC_ADDR_ACCUM    8'hD5
`define AACC_ADDR_OPSEL    8'hD6

// ---------------------------------------------------------------
// Control/status fields
// ---------------------------------------------------------------
`define AACC_BIT_BUSY      7
`define AACC_BIT_OVF       6
`define AACC_BIT_CARRY     5
`define AACC_BIT_CLEAR     4
`define AACC_CTRL_RSVD     4'hF

// ---------------------------------------------------------------
// Mode register fields
// ---------------------------------------------------------------
`define AACC_BIT_RSHIFT    7
`define AACC_BIT_CIRC      6
`define AACC_BIT_SCE       5
`define AACC_MODE_RESET    8'h00

// ---------------------------------------------------------------
// Limits and counts
// ---------------------------------------------------------------
`define AACC_OVF_LIMIT     64'h0000_0000_0000_FFFF
`define AACC_CALC_CYCLES   5'h04
`define AACC_NORM_MAX      5'h1F
`define AACC_OPA_BYTES     3'h4
`define AACC_ACC_BYTES     3'h5

// ---------------------------------------------------------------
// Host-side APB registers
// ---------------------------------------------------------------
`define AACC_APB_CMD       8'h00
`define AACC_APB_STATUS    8'h04
`define AACC_CMD_WRITE     16
`define AACC_CMD_READ      17

`endif

// ===== rtl/aacc_pkg.sv
// Types shared by both ends of the arithmetic accelerator
package aacc_pkg;

  typedef enum logic [1:0] {
    AACC_OP_MUL,
    AACC_OP_DIV,
    AACC_OP_SHIFT
  } aacc_op_type;

  typedef enum logic [2:0] {
    AACC_ST_IDLE,
    AACC_ST_LOAD,
    AACC_ST_CALC,
    AACC_ST_SHIFT,
    AACC_ST_NORM
  } aacc_state_type;

  typedef enum logic [1:0] {
    AACC_H_IDLE,
    AACC_H_ISSUE,
    AACC_H_WAIT
  } aacc_host_state_type;

endpackage : aacc_pkg

// ===== rtl/aacc_sfr_if.sv
// Register port between processor-side controller and accelerator
`timescale 1ns/100ps
`default_nettype none

interface aacc_sfr_if;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_rdata;

  modport device (
    input  sfr_addr,
    input  sfr_wdata,
    input  sfr_wr,
    input  sfr_rd,
    output sfr_rdata
  );

  modport host (
    output sfr_addr,
    output sfr_wdata,
    output sfr_wr,
    output sfr_rd,
    input  sfr_rdata
  );
endinterface : aacc_sfr_if

`default_nettype wire

// ===== rtl/aacc_device.sv
// Arithmetic accelerator register block: multiply, divide, shift, normalize
// Functional notes
// RQ1 - Busy rises on first operand byte load
// RQ2 - Busy clears itself when results ready
// RQ3 - Writing busy low aborts and initializes; code does so only while busy, not when idle
// RQ4 - Overflow cleared by reset and initialization
// RQ5 - Overflow on divide by zero, result above FFFFh
// RQ6 - Carry bit joins shifts when enabled
// RQ7 - New operation never clears carry bit
// RQ8 - Clear strobe wipes A, B, accumulator
// RQ9 - Clear strobe always reads zero
// RQ10 - A holds numerator or multiplicand
// RQ11 - A returns quotient, product, shift, mantissa
// RQ12 - A is four sequential bytes, one address
// RQ13 - B holds divisor or multiplier
// RQ14 - B returns division remainder
// RQ15 - B is four sequential bytes, one address
// RQ16 - 40-bit accumulator adds multiply/divide results
// RQ17 - Accumulator reads MSB first, five reads
// RQ18 - Accumulator writes LSB first, partial allowed
// RQ19 - Accumulator cleared by reset, clear, busy set
// RQ20 - Five zero writes clear accumulator
// RQ21 - Carry enters LSB left, MSB right
// RQ22 - Zero shift count normalizes, reports count
// RQ23 - Low four control bits read one
`include "aacc_params.svh"
`timescale 1ns/100ps
`default_nettype none

module aacc_device (
  input  wire logic clk,
  input  wire logic nrst,
  aacc_sfr_if.device sfr,
  output logic      busy_out,
  output logic      overflow_out
);
  import aacc_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  aacc_state_type state_reg;
  aacc_op_type    op_reg;
  logic [31:0]    a_reg;
  logic [31:0]    b_reg;
  logic [39:0]    acc_reg;
  logic [7:0]     mode_reg;
  logic           ovf_reg;
  logic           carry_reg;
  logic [4:0]     cnt_reg;
  logic [2:0]     seq_reg;
  logic [8:0]     last_reg;
  logic [7:0]     rdata_reg;

  // ---------------------------------------------------------------
  // Access decode and byte sequencing
  // ---------------------------------------------------------------
  wire       access    = sfr.sfr_wr | sfr.sfr_rd;
  wire [8:0] this_acc  = {sfr.sfr_addr, sfr.sfr_wr};
  wire       same_acc  = access && (this_acc == last_reg);
  wire [2:0] seq_cur   = same_acc ? seq_reg : 3'h0;
  wire       hit_mode  = sfr.sfr_addr == `AACC_ADDR_MODE;
  wire       hit_ctrl  = sfr.sfr_addr == `AACC_ADDR_CTRL;
  wire       hit_opa   = sfr.sfr_addr == `AACC_ADDR_OPA;
  wire       hit_opb   = sfr.sfr_addr == `AACC_ADDR_OPB;
  wire       hit_acc   = sfr.sfr_addr == `AACC_ADDR_ACCUM;
  wire       hit_opsel = sfr.sfr_addr == `AACC_ADDR_OPSEL;
  wire [2:0] seq_wrap  = hit_acc ? `AACC_ACC_BYTES : `AACC_OPA_BYTES;
  wire [2:0] seq_next  = (seq_cur == seq_wrap - 3'h1) ? 3'h0 : seq_cur + 3'h1;
  wire       busy      = state_reg != AACC_ST_IDLE;
  wire       running   = busy && state_reg != AACC_ST_LOAD;

  wire       wr_ctrl   = sfr.sfr_wr && hit_ctrl;
  wire       wr_mode   = sfr.sfr_wr && hit_mode && !running;
  // Operand writes are ignored while a calculation is in flight
  wire       wr_opa    = sfr.sfr_wr && hit_opa && !running;
  wire       wr_opb    = sfr.sfr_wr && hit_opb && !running;
  wire       wr_acc    = sfr.sfr_wr && hit_acc && !running;
  wire       wr_go     = sfr.sfr_wr && hit_opsel && !running;
  wire       abort     = wr_ctrl && !sfr.sfr_wdata[`AACC_BIT_BUSY] && busy;
  wire       busy_sw   = wr_ctrl && sfr.sfr_wdata[`AACC_BIT_BUSY] && !busy;
  wire       clear_all = wr_ctrl && sfr.sfr_wdata[`AACC_BIT_CLEAR];
  wire       busy_set  = busy_sw || (!busy && (wr_opa || wr_opb));

  // Byte lane positions: A and B low byte first, accumulator reads high first
  wire [4:0]  ab_sh     = {seq_cur[1:0], 3'b000};
  wire [5:0]  accw_sh   = {seq_cur, 3'b000};
  wire [2:0]  accr_idx  = 3'h4 - seq_cur;
  wire [5:0]  accr_sh   = {accr_idx, 3'b000};
  wire [31:0] byte_ab   = {24'h000000, sfr.sfr_wdata} << ab_sh;
  wire [31:0] mask_ab   = 32'h0000_00FF << ab_sh;
  wire [39:0] byte_acc  = {32'h0000_0000, sfr.sfr_wdata} << accw_sh;
  wire [39:0] mask_acc  = 40'h00_0000_00FF << accw_sh;
  wire [31:0] a_rd      = a_reg >> ab_sh;
  wire [31:0] b_rd      = b_reg >> ab_sh;
  wire [39:0] acc_rd    = acc_reg >> accr_sh;

  // ---------------------------------------------------------------
  // Arithmetic
  // ---------------------------------------------------------------
  wire        div_zero  = b_reg == 32'h0000_0000;
  wire [63:0] product   = a_reg * b_reg;
  wire [31:0] quotient  = div_zero ? 32'h0000_0000 : a_reg / b_reg;
  wire [31:0] remainder = div_zero ? a_reg : a_reg % b_reg;
  wire        is_mul    = op_reg == AACC_OP_MUL;
  wire [63:0] result    = is_mul ? product : {32'h0000_0000, quotient};
  wire [39:0] acc_sum   = acc_reg + result[39:0];
  wire        res_ovf   = (!is_mul && div_zero) || (result > `AACC_OVF_LIMIT);

  // One shift step; carry paths follow the enable and circular bits
  wire        sh_right  = mode_reg[`AACC_BIT_RSHIFT];
  wire        sh_circ   = mode_reg[`AACC_BIT_CIRC];
  wire        sh_sce    = mode_reg[`AACC_BIT_SCE];
  wire        in_left   = sh_sce ? carry_reg : (sh_circ & a_reg[31]);
  wire        in_right  = sh_sce ? carry_reg : (sh_circ & a_reg[0]);
  wire [31:0] a_shift   = sh_right ? {in_right, a_reg[31:1]} : {a_reg[30:0], in_left};
  wire        out_bit   = sh_right ? a_reg[0] : a_reg[31];
  wire        norm_done = a_reg[31] || (a_reg == 32'h0000_0000) || (cnt_reg == `AACC_NORM_MAX);

  wire calc_end  = state_reg == AACC_ST_CALC && cnt_reg == 5'h01;
  wire shift_end = state_reg == AACC_ST_SHIFT && cnt_reg == 5'h01;
  wire norm_end  = state_reg == AACC_ST_NORM && norm_done;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= AACC_ST_IDLE;
      op_reg    <= AACC_OP_MUL;
      cnt_reg   <= 5'h00;
    end else if (abort) begin
      state_reg <= AACC_ST_IDLE;                                 // RQ3
    end else begin
      case (state_reg)
        AACC_ST_IDLE, AACC_ST_LOAD: begin
          if (wr_go) begin
            op_reg <= aacc_op_type'(sfr.sfr_wdata[1:0]);
            if (sfr.sfr_wdata[1:0] == 2'(AACC_OP_SHIFT)) begin
              // Zero count selects normalization
              state_reg <= (mode_reg[4:0] == 5'h00) ? AACC_ST_NORM : AACC_ST_SHIFT; // RQ22
              cnt_reg   <= mode_reg[4:0];
            end else begin
              state_reg <= AACC_ST_CALC;
              cnt_reg   <= `AACC_CALC_CYCLES;
            end
          end else if (busy_set) begin
            state_reg <= AACC_ST_LOAD;                           // RQ1
          end
        end
        AACC_ST_CALC, AACC_ST_SHIFT: begin
          cnt_reg <= cnt_reg - 5'h01;
          if (calc_end || shift_end) state_reg <= AACC_ST_IDLE;  // RQ2
        end
        AACC_ST_NORM: begin
          if (norm_done) state_reg <= AACC_ST_IDLE;             // RQ2
          else cnt_reg <= cnt_reg + 5'h01;
        end
        default: state_reg <= AACC_ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Operand, accumulator and flag registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      a_reg   <= 32'h0000_0000;
      b_reg   <= 32'h0000_0000;
    end else if (clear_all) begin
      a_reg   <= 32'h0000_0000;                                  // RQ8
      b_reg   <= 32'h0000_0000;                                  // RQ8
    end else if (calc_end) begin
      a_reg   <= result[31:0];                                   // RQ11
      if (!is_mul) b_reg <= remainder;                           // RQ14
    end else if (state_reg == AACC_ST_SHIFT || (state_reg == AACC_ST_NORM && !norm_done)) begin
      a_reg   <= a_shift;                                        // RQ11
    end else begin
      // First byte of a sequence clears the upper bytes
      if (wr_opa) a_reg <= (seq_cur == 3'h0) ? byte_ab : (a_reg & ~mask_ab) | byte_ab; // RQ10 RQ12
      if (wr_opb) b_reg <= (seq_cur == 3'h0) ? byte_ab : (b_reg & ~mask_ab) | byte_ab; // RQ13 RQ15
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_reg <= 40'h00_0000_0000;
    end else if (clear_all || busy_set) begin
      acc_reg <= 40'h00_0000_0000;                               // RQ19
    end else if (calc_end) begin
      acc_reg <= acc_sum;                                        // RQ16
    end else if (wr_acc) begin
      acc_reg <= (acc_reg & ~mask_acc) | byte_acc;               // RQ18 RQ20
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ovf_reg <= 1'b0;                                           // RQ4
    end else if (calc_end && res_ovf) begin
      ovf_reg <= 1'b1;                                           // RQ5
    end else if (abort) begin
      ovf_reg <= 1'b0;                                           // RQ4
    end
  end

  // Carry follows software writes and the shift path only, never a start
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      carry_reg <= 1'b0;
    end else if (wr_ctrl) begin
      carry_reg <= sfr.sfr_wdata[`AACC_BIT_CARRY];               // RQ7
    end else if (state_reg == AACC_ST_SHIFT && sh_sce && sh_circ) begin
      carry_reg <= out_bit;                                      // RQ6 RQ21
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= `AACC_MODE_RESET;
    end else if (abort) begin
      mode_reg <= {1'b0, mode_reg[6:5], 5'h00};
    end else if (norm_end) begin
      mode_reg <= {mode_reg[7:5], cnt_reg};                      // RQ22
    end else if (wr_mode) begin
      mode_reg <= sfr.sfr_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Read path, answered one cycle after the read strobe
  // ---------------------------------------------------------------
  wire [7:0] ctrl_rd = {busy, ovf_reg, carry_reg, 1'b0, `AACC_CTRL_RSVD}; // RQ9 RQ23
  wire [7:0] rd_mux  = hit_mode  ? mode_reg :
                       hit_ctrl  ? ctrl_rd :
                       hit_opa   ? a_rd[7:0] :
                       hit_opb   ? b_rd[7:0] :
                       hit_acc   ? acc_rd[7:0] :                 // RQ17
                       hit_opsel ? {6'h00, op_reg} : 8'h00;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
      seq_reg   <= 3'h0;
      last_reg  <= 9'h000;
    end else if (access) begin
      if (sfr.sfr_rd) rdata_reg <= rd_mux;
      seq_reg   <= seq_next;                                     // RQ12 RQ15 RQ17
      last_reg  <= this_acc;
    end
  end

  assign sfr.sfr_rdata = rdata_reg;
  assign busy_out      = busy;
  assign overflow_out  = ovf_reg;

endmodule : aacc_device

`default_nettype wire

// ===== rtl/aacc_ctrl.sv
// Processor-side controller: APB slave issuing byte accesses to the accelerator
`include "aacc_params.svh"
`timescale 1ns/100ps
`default_nettype none

module aacc_ctrl (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  aacc_sfr_if.host         sfr
);
  import aacc_pkg::*;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  aacc_host_state_type hst_reg;
  logic [7:0]          addr_reg;
  logic [7:0]          wdata_reg;
  logic                wr_reg;
  logic                rd_reg;
  logic [7:0]          rcap_reg;

  wire apb_acc  = psel && penable;
  wire hit_cmd  = paddr[7:0] == `AACC_APB_CMD && paddr[31:8] == 24'h000000;
  wire hit_stat = paddr[7:0] == `AACC_APB_STATUS && paddr[31:8] == 24'h000000;
  wire pending  = hst_reg != AACC_H_IDLE;
  // A command written while one is pending is dropped
  wire cmd_go   = apb_acc && pwrite && hit_cmd && !pending;
  wire is_wr    = pwdata[`AACC_CMD_WRITE];
  wire is_rd    = pwdata[`AACC_CMD_READ] && !is_wr;                  // RQ12 RQ15 RQ17 RQ18

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hst_reg   <= AACC_H_IDLE;
      addr_reg  <= 8'h00;
      wdata_reg <= 8'h00;
      wr_reg    <= 1'b0;
      rd_reg    <= 1'b0;
    end else begin
      case (hst_reg)
        AACC_H_IDLE: begin
          if (cmd_go && (is_wr || is_rd)) begin
            addr_reg  <= pwdata[7:0];
            wdata_reg <= pwdata[15:8];
            wr_reg    <= is_wr;
            rd_reg    <= is_rd;
            hst_reg   <= AACC_H_ISSUE;
          end
        end
        AACC_H_ISSUE: begin
          wr_reg  <= 1'b0;
          rd_reg  <= 1'b0;
          hst_reg <= rd_reg ? AACC_H_WAIT : AACC_H_IDLE;
        end
        AACC_H_WAIT: hst_reg <= AACC_H_IDLE;
        default:     hst_reg <= AACC_H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rcap_reg <= 8'h00;
    else if (hst_reg == AACC_H_WAIT) rcap_reg <= sfr.sfr_rdata;
  end

  // ---------------------------------------------------------------
  // APB answer: no wait states, error on unmapped address
  // ---------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = apb_acc && !hit_cmd && !hit_stat;
  assign prdata  = hit_stat ? {16'h0000, rcap_reg, 7'h00, pending} :
                   hit_cmd  ? {14'h0000, rd_reg, wr_reg, wdata_reg, addr_reg} : 32'h0000_0000;

  assign sfr.sfr_addr  = addr_reg;
  assign sfr.sfr_wdata = wdata_reg;
  assign sfr.sfr_wr    = wr_reg;
  assign sfr.sfr_rd    = rd_reg;

endmodule : aacc_ctrl

`default_nettype wire

// ===== verif/aacc_monitor.sv
// Concurrent checks on the register port between controller and accelerator
`include "aacc_params.svh"
`timescale 1ns/100ps
`default_nettype none

module aacc_monitor (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       busy_out,
  input wire logic       overflow_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ---------------------------------------------------------------
  // Decoded port events
  // ---------------------------------------------------------------
  wire logic opnd_wr = sfr_wr && (sfr_addr == `AACC_ADDR_OPA || sfr_addr == `AACC_ADDR_OPB);
  wire logic ctrl_wr = sfr_wr && (sfr_addr == `AACC_ADDR_CTRL);
  wire logic ctrl_rd = sfr_rd && (sfr_addr == `AACC_ADDR_CTRL);
  // Shift length depends on the mode count, so only calc ops are timed
  wire logic calc_go = sfr_wr && (sfr_addr == `AACC_ADDR_OPSEL) && (sfr_wdata[1:0] != 2'b10)
                       && busy_out;
  wire logic abort   = ctrl_wr && !sfr_wdata[`AACC_BIT_BUSY] && busy_out;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  busy_on_load_a: assert property (opnd_wr && !busy_out |=> busy_out)
    else $error("busy did not rise on operand load");
  busy_cause_a: assert property ($rose(busy_out) |-> $past(sfr_wr))
    else $error("busy rose without a register write");
  calc_done_a: assert property (calc_go |=> busy_out [*4] ##1 !busy_out)
    else $error("calculation busy span wrong");
  abort_init_a: assert property (abort |=> !busy_out)
    else $error("abort did not drop busy");
  ctrl_const_a: assert property (ctrl_rd |=> sfr_rdata[4:0] == 5'h0F)
    else $error("control low bits read wrong");
  ctrl_flags_a: assert property (ctrl_rd |=> sfr_rdata[7] == $past(busy_out) &&
                                 sfr_rdata[6] == $past(overflow_out))
    else $error("control flags disagree with outputs");
  ovf_cause_a: assert property ($rose(overflow_out) |-> $past(busy_out))
    else $error("overflow rose outside an operation");
  ovf_hold_a: assert property (overflow_out && !ctrl_wr |=> overflow_out)
    else $error("overflow cleared without initialization");

  cover property (calc_go ##5 !busy_out);
  cover property (abort);
  cover property ($rose(overflow_out));
endmodule : aacc_monitor

`default_nettype wire

// ===== verif/test_arithmetic_accelerator_regs.sv
// Self-checking bench: APB controller driving the accelerator over the register port
`include "aacc_params.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin errors++; $display("wrong value at %0t: got %0h expected %0h", $time, g, x); end end

module test_arithmetic_accelerator_regs;
  import aacc_pkg::*;
  localparam logic [1:0]  wr_k = 2'b01;
  localparam logic [1:0]  rd_k = 2'b10;
  localparam logic [39:0] pre  = 40'h01_0000_0100;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        busy_out;
  logic        overflow_out;
  logic [7:0]  b;
  logic [31:0] v, r, ea, eb;
  logic [39:0] w40, res;
  logic [63:0] p;
  logic        e, ov;
  logic [31:0] ca [4] = '{32'h123, 32'h3E8, 32'h0001_0000, 32'h5};
  logic [31:0] cb [4] = '{32'h45, 32'h7, 32'h3, 32'h0};
  logic [1:0]  co [4] = '{2'b00, 2'b01, 2'b00, 2'b01};
  int          errors = 0;
  int          num_checks = 0;

  aacc_sfr_if sfr ();
  aacc_ctrl u_aacc_ctrl (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sfr(sfr));
  aacc_device u_aacc_device (.clk(clk), .nrst(nrst), .sfr(sfr), .busy_out(busy_out),
    .overflow_out(overflow_out));
  aacc_monitor u_aacc_monitor (.clk(clk), .nrst(nrst), .sfr_addr(sfr.sfr_addr),
    .sfr_wdata(sfr.sfr_wdata), .sfr_wr(sfr.sfr_wr), .sfr_rd(sfr.sfr_rd),
    .sfr_rdata(sfr.sfr_rdata), .busy_out(busy_out), .overflow_out(overflow_out));

  always #25 clk = ~clk;

  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {24'h0, a};
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Polls pending so a second command is never dropped
  task automatic sfr_io(input logic [1:0] k, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    logic [31:0] s;
    logic        x;
    apb(1'b1, `AACC_APB_CMD, {14'h0, k, d, a}, s, x);
    do apb(1'b0, `AACC_APB_STATUS, 32'h0, s, x); while (s[0] !== 1'b0);
    q = s[15:8];
  endtask : sfr_io

  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    for (int i = 0; i < 4; i++) sfr_io(wr_k, a, d[8*i +: 8], b);
  endtask : wr32

  task automatic rd32(input logic [7:0] a, output logic [31:0] q);
    for (int i = 0; i < 4; i++) begin
      sfr_io(rd_k, a, 8'h00, b);
      q[8*i +: 8] = b;
    end
  endtask : rd32

  task automatic wracc(input logic [39:0] d);
    for (int i = 0; i < 5; i++) sfr_io(wr_k, `AACC_ADDR_ACCUM, d[8*i +: 8], b);
  endtask : wracc

  task automatic rdacc(output logic [39:0] q);
    for (int i = 4; i >= 0; i--) begin
      sfr_io(rd_k, `AACC_ADDR_ACCUM, 8'h00, b);
      q[8*i +: 8] = b;
    end
  endtask : rdacc

  task automatic waitdone;
    do sfr_io(rd_k, `AACC_ADDR_CTRL, 8'h00, b); while (b[7] !== 1'b0);
  endtask : waitdone

  task automatic shift_case(input logic [7:0] m, input logic [31:0] a, input logic [31:0] x,
                            input logic [7:0] mx);
    sfr_io(wr_k, `AACC_ADDR_MODE, m, b);
    wr32(`AACC_ADDR_OPA, a);
    sfr_io(wr_k, `AACC_ADDR_OPSEL, 8'h02, b);
    waitdone;
    rd32(`AACC_ADDR_OPA, v);
    `CHK(v, x)
    sfr_io(rd_k, `AACC_ADDR_MODE, 8'h00, b);
    `CHK(b, mx)
  endtask : shift_case

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    sfr_io(rd_k, `AACC_ADDR_CTRL, 8'h00, b);
    `CHK(b, 8'h0F)
    apb(1'b0, 8'h08, 32'h0, r, e);
    `CHK(e, 1'b1)
    for (int i = 0; i < 4; i++) begin
      if (i == 3) begin
        // Abort mid-load clears the overflow left by the previous case
        sfr_io(wr_k, `AACC_ADDR_OPA, 8'h11, b);
        sfr_io(wr_k, `AACC_ADDR_CTRL, 8'h00, b);
        sfr_io(rd_k, `AACC_ADDR_CTRL, 8'h00, b);
        `CHK(b, 8'h0F)
      end
      p = {32'h0, ca[i]} * {32'h0, cb[i]};
      if (co[i] == 2'b00) begin
        ea = p[31:0];
        res = p[39:0];
        ov = (p > 64'hFFFF);
      end else begin
        ea = (cb[i] != 0) ? ca[i] / cb[i] : 32'h0;
        eb = (cb[i] != 0) ? ca[i] % cb[i] : ca[i];
        res = {8'h0, ea};
        ov = (cb[i] == 0) || (ea > 32'hFFFF);
      end
      wr32(`AACC_ADDR_OPA, ca[i]);
      wr32(`AACC_ADDR_OPB, cb[i]);
      wracc(pre);
      sfr_io(wr_k, `AACC_ADDR_OPSEL, {6'h0, co[i]}, b);
      waitdone;
      rd32(`AACC_ADDR_OPA, v);
      `CHK(v, ea)
      if (co[i] == 2'b01) begin
        rd32(`AACC_ADDR_OPB, v);
        `CHK(v, eb)
      end
      if (cb[i] != 0) begin
        rdacc(w40);
        `CHK(w40, pre + res)
      end
      sfr_io(rd_k, `AACC_ADDR_CTRL, 8'h00, b);
      `CHK(b, {1'b0, ov, 6'h0F})
    end
    // Busy low while idle: no initialization, overflow stays
    sfr_io(wr_k, `AACC_ADDR_CTRL, 8'h10, b);
    sfr_io(rd_k, `AACC_ADDR_CTRL, 8'h00, b);
    `CHK(b, 8'h4F)
    rd32(`AACC_ADDR_OPA, v);
    `CHK(v, 32'h0)
    rd32(`AACC_ADDR_OPB, v);
    `CHK(v, 32'h0)
    rdacc(w40);
    `CHK(w40, 40'h0)
    wracc(40'hA5_A5A5_A5A5);
    wracc(40'h0);
    rdacc(w40);
    `CHK(w40, 40'h0)
    wracc(40'h12);
    sfr_io(wr_k, `AACC_ADDR_CTRL, 8'h80, b);
    sfr_io(wr_k, `AACC_ADDR_CTRL, 8'h00, b);
    rdacc(w40);
    `CHK(w40, 40'h0)
    sfr_io(wr_k, `AACC_ADDR_CTRL, 8'h20, b);
    shift_case(8'h21, 32'h8000_0001, 32'h0000_0003, 8'h21);
    shift_case(8'hA1, 32'h0000_0002, 32'h8000_0001, 8'hA1);
    sfr_io(rd_k, `AACC_ADDR_CTRL, 8'h00, b);
    `CHK(b, 8'h2F)
    shift_case(8'h00, 32'h0000_1000, 32'h8000_0000, 8'h13);
    close_out;
  end

  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    close_out;
  end
endmodule : test_arithmetic_accelerator_regs

`default_nettype wire
